// ==== common/tdmr_defines.svh ====
/*
  register indices, field positions, reset values and masks of the tdm
  receive port; assumes word-aligned registers at byte address 4*index.
*/
`ifndef TDMR_DEFINES_SVH
`define TDMR_DEFINES_SVH
// ============================================================
// register indices
`define TDMR_IDX_RATE 6'h06
`define TDMR_IDX_TIMING 6'h07
`define TDMR_IDX_FORMAT 6'h08
`define TDMR_IDX_SLOTS 6'h09
`define TDMR_IDX_DEVSLOT 6'h0a
`define TDMR_IDX_STATUS 6'h0b
`define TDMR_IDX_SAMPLE 6'h0c
`define TDMR_IDX_F 7:2
`define TDMR_HI_F 31:8
`define TDMR_HSIZE_WORD 3'h2
// ============================================================
// reset values and writable masks
`define TDMR_RST_RATE 8'h09
`define TDMR_RST_TIMING 8'h02
`define TDMR_RST_FORMAT 8'h4a
`define TDMR_RST_SLOTS 8'h10
`define TDMR_RST_DEVSLOT 8'h00
`define TDMR_MSK_RATE 8'h7f
`define TDMR_MSK_TIMING 8'h7f
`define TDMR_MSK_FORMAT 8'hff
`define TDMR_MSK_SLOTS 8'hff
`define TDMR_MSK_DEVSLOT 8'h0f
// ============================================================
// field positions
`define TDMR_POL_B 0
`define TDMR_RATE_F 3:1
`define TDMR_AUTO_B 4
`define TDMR_FAM_B 5
`define TDMR_LOCK_B 6
`define TDMR_RSV_B 7
`define TDMR_EDGE_B 0
`define TDMR_OFS_F 5:1
`define TDMR_JUST_B 6
`define TDMR_SLEN_F 1:0
`define TDMR_WLEN_F 3:2
`define TDMR_CHSEL_F 5:4
`define TDMR_SENSE_F 7:6
`define TDMR_SLOTL_F 3:0
`define TDMR_SLOTR_F 7:4
`define TDMR_DEV_F 3:0
// ============================================================
// lengths in bits and rate-detect boundaries in hz
`define TDMR_LEN8 6'd8
`define TDMR_LEN16 6'd16
`define TDMR_LEN20 6'd20
`define TDMR_LEN24 6'd24
`define TDMR_LEN32 6'd32
`define TDMR_BND0_HZ 11300
`define TDMR_BND1_HZ 19000
`define TDMR_BND2_HZ 27000
`define TDMR_BND3_HZ 38000
`define TDMR_BND4_HZ 66000
`define TDMR_BND5_HZ 130000
`endif

// ==== common/tdmr_pkg.sv ====
/*
  types and length decoders of the tdm receive port; assumes the
  defines header is on the include path.
*/
`include "tdmr_defines.svh"
package tdmr_pkg;
    // ============================================================
    // encodings
    typedef enum logic [2:0] {
        TDMR_R8K = 3'b000, TDMR_R16K = 3'b001, TDMR_R24K = 3'b010,
        TDMR_R32K = 3'b011, TDMR_R48K = 3'b100, TDMR_R96K = 3'b101,
        TDMR_R192K = 3'b110, TDMR_RRSV = 3'b111
    } tdmr_rate_t;
    typedef enum logic [1:0] {
        TDMR_CH_ADDR = 2'b00, TDMR_CH_LEFT = 2'b01,
        TDMR_CH_RIGHT = 2'b10, TDMR_CH_MIX = 2'b11
    } tdmr_chsel_t;
    typedef enum logic [1:0] {
        TDMR_ST_IDLE = 2'b00, TDMR_ST_LEAD = 2'b01, TDMR_ST_DATA = 2'b10
    } tdmr_state_t;
    // ============================================================
    // carriers
    typedef struct packed {
        logic pol;
        logic edge_fall;
        logic justify_right;
        logic [4:0] offset;
        tdmr_chsel_t chsel;
        logic [1:0] wlen;
        logic [1:0] slen;
        logic [3:0] slot_l;
        logic [3:0] slot_r;
        logic [3:0] slot_dev;
    } tdmr_lcfg_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [5:0] idx;
    } tdmr_ahb_req_t;
    // ============================================================
    // length decoders
    function automatic logic [5:0] tdmr_wlen_bits(input logic [1:0] c);
        unique case (c)
            2'b00: return `TDMR_LEN16;
            2'b01: return `TDMR_LEN20;
            2'b10: return `TDMR_LEN24;
            2'b11: return `TDMR_LEN32;
        endcase
    endfunction
    // reserved slot code falls back to the longest slot
    function automatic logic [5:0] tdmr_slen_bits(input logic [1:0] c);
        unique case (c)
            2'b00: return `TDMR_LEN16;
            2'b01: return `TDMR_LEN24;
            2'b10: return `TDMR_LEN32;
            2'b11: return `TDMR_LEN32;
        endcase
    endfunction
    function automatic logic [5:0] tdmr_sense_bits(input logic [1:0] c);
        unique case (c)
            2'b00: return `TDMR_LEN8;
            2'b01: return `TDMR_LEN16;
            2'b10: return `TDMR_LEN24;
            2'b11: return `TDMR_LEN32;
        endcase
    endfunction
endpackage

// ==== rtl/tdmr_port.sv ====
/*
  tdm receive port: ahb-lite register slave on clk, frame and slot
  capture on serial_bit_clock, mono sample handed to clk domain.
  assumes the host drives frame_sync and serial_data in step with
  serial_bit_clock, and that configuration changes while the link idles.
*/
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tdmr_defines.svh"
module tdmr_port #(
    parameter int CLK_HZ = 100000000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic serial_bit_clock,
    input wire logic frame_sync,
    input wire logic serial_data,
    output logic [31:0] sample_data,
    output logic sample_valid,
    output logic amp_clock_lock,
    output logic amp_base_441,
    output logic [5:0] sense_word_bits,
    output logic [2:0] active_rate
);
    localparam logic [15:0] TH0 = 16'(CLK_HZ / `TDMR_BND0_HZ);
    localparam logic [15:0] TH1 = 16'(CLK_HZ / `TDMR_BND1_HZ);
    localparam logic [15:0] TH2 = 16'(CLK_HZ / `TDMR_BND2_HZ);
    localparam logic [15:0] TH3 = 16'(CLK_HZ / `TDMR_BND3_HZ);
    localparam logic [15:0] TH4 = 16'(CLK_HZ / `TDMR_BND4_HZ);
    localparam logic [15:0] TH5 = 16'(CLK_HZ / `TDMR_BND5_HZ);
    // the period counter is 16 bits wide; slowest frame must fit
    if (CLK_HZ < 1000000 || CLK_HZ > 400000000)
    begin : g_bad_clk
        $error("clock rate outside what the rate detector serves");
    end

    // ============================================================
    // bus slave
    tdmr_pkg::tdmr_ahb_req_t req_d, req_q;
    logic [7:0] cfg0_q, cfg1_q, cfg2_q, cfg3_q, dev_q;
    logic [7:0] cfg0_d, cfg1_d, cfg2_d, cfg3_d, dev_d;
    logic [31:0] hrdata_q, rd_w, sample_q;
    logic hreadyout_q, valid_q, lock_q, base_q;
    logic [5:0] sense_q;
    logic [2:0] rate_q, det_q;
    logic [2:0] det_d, rate_d;
    logic [15:0] per_q, per_d;
    logic tg_s1_q, tg_s2_q, tg_s3_q;

    function automatic logic [7:0] upd(input logic hit, input logic [7:0] old,
                                       input logic [7:0] nv,
                                       input logic [7:0] msk);
        return hit ? (nv & msk) : old;
    endfunction

    wire addr_ok = hsel & hready & htrans[1] & (hsize == `TDMR_HSIZE_WORD);
    wire addr_in = haddr[`TDMR_HI_F] == '0;
    assign req_d = '{valid: addr_ok & addr_in, write: hwrite,
                     idx: haddr[`TDMR_IDX_F]};
    wire wr_w = req_q.valid & req_q.write;
    wire wr_rate = wr_w & (req_q.idx == `TDMR_IDX_RATE);
    // masks drop reserved bits so they read back zero
    assign cfg0_d = upd(wr_rate, cfg0_q, hwdata[7:0], `TDMR_MSK_RATE);
    assign cfg1_d = upd(wr_w & (req_q.idx == `TDMR_IDX_TIMING), cfg1_q,
                        hwdata[7:0], `TDMR_MSK_TIMING);
    assign cfg2_d = upd(wr_w & (req_q.idx == `TDMR_IDX_FORMAT), cfg2_q,
                        hwdata[7:0], `TDMR_MSK_FORMAT);
    assign cfg3_d = upd(wr_w & (req_q.idx == `TDMR_IDX_SLOTS), cfg3_q,
                        hwdata[7:0], `TDMR_MSK_SLOTS);
    assign dev_d = upd(wr_w & (req_q.idx == `TDMR_IDX_DEVSLOT), dev_q,
                       hwdata[7:0], `TDMR_MSK_DEVSLOT);

    // reads use next values so a read right after a write sees it
    wire [5:0] ridx = req_d.idx;
    assign rd_w = !(req_d.valid && !hwrite) ? '0 :
        (ridx == `TDMR_IDX_RATE) ? 32'(cfg0_d) :
        (ridx == `TDMR_IDX_TIMING) ? 32'(cfg1_d) :
        (ridx == `TDMR_IDX_FORMAT) ? 32'(cfg2_d) :
        (ridx == `TDMR_IDX_SLOTS) ? 32'(cfg3_d) :
        (ridx == `TDMR_IDX_DEVSLOT) ? 32'(dev_d) :
        (ridx == `TDMR_IDX_STATUS) ? 32'({lock_q, rate_q}) :
        (ridx == `TDMR_IDX_SAMPLE) ? sample_q : '0;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            req_q <= '0;
            hrdata_q <= '0;
            hreadyout_q <= 1'b1;
            cfg0_q <= `TDMR_RST_RATE;
            cfg1_q <= `TDMR_RST_TIMING;
            cfg2_q <= `TDMR_RST_FORMAT;
            cfg3_q <= `TDMR_RST_SLOTS;
            dev_q <= `TDMR_RST_DEVSLOT;
        end
        else
        begin
            req_q <= req_d;
            hrdata_q <= rd_w;
            hreadyout_q <= 1'b1;
            cfg0_q <= cfg0_d;
            cfg1_q <= cfg1_d;
            cfg2_q <= cfg2_d;
            cfg3_q <= cfg3_d;
            dev_q <= dev_d;
        end
    end

    // ============================================================
    // frame event crossing, rate detection and control outputs
    logic tgl_q;
    logic [31:0] link_out_q;
    wire ev_w = tg_s2_q ^ tg_s3_q;
    assign per_d = ev_w ? '0 : (per_q == '1 ? per_q : per_q + 16'd1);
    // frame period in clk cycles picks the nearest rate code
    assign det_d = !ev_w ? det_q :
        (per_q >= TH0) ? tdmr_pkg::TDMR_R8K :
        (per_q >= TH1) ? tdmr_pkg::TDMR_R16K :
        (per_q >= TH2) ? tdmr_pkg::TDMR_R24K :
        (per_q >= TH3) ? tdmr_pkg::TDMR_R32K :
        (per_q >= TH4) ? tdmr_pkg::TDMR_R48K :
        (per_q >= TH5) ? tdmr_pkg::TDMR_R96K : tdmr_pkg::TDMR_R192K;
    // inverted sense: a set bit switches detection off
    assign rate_d = cfg0_q[`TDMR_AUTO_B] ? cfg0_q[`TDMR_RATE_F] : det_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
            per_q <= '0;
            det_q <= tdmr_pkg::TDMR_R48K;
            rate_q <= tdmr_pkg::TDMR_R48K;
            sample_q <= '0;
            valid_q <= 1'b0;
            lock_q <= 1'b0;
            base_q <= 1'b0;
            sense_q <= `TDMR_LEN16;
        end
        else
        begin
            tg_s1_q <= tgl_q;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
            per_q <= per_d;
            det_q <= det_d;
            rate_q <= rate_d;
            // link word was loaded on the same bit-clock edge that flipped the toggle
            sample_q <= ev_w ? link_out_q : sample_q;
            valid_q <= ev_w;
            lock_q <= cfg0_q[`TDMR_LOCK_B];
            base_q <= cfg0_q[`TDMR_LOCK_B] & cfg0_q[`TDMR_FAM_B];
            sense_q <= tdmr_pkg::tdmr_sense_bits(cfg2_q[`TDMR_SENSE_F]);
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    assign sample_data = sample_q;
    assign sample_valid = valid_q;
    assign amp_clock_lock = lock_q;
    assign amp_base_441 = base_q;
    assign sense_word_bits = sense_q;
    assign active_rate = rate_q;

    // ============================================================
    // configuration into the link domain
    tdmr_pkg::tdmr_lcfg_t cfg_w, lcfg_s1_q, lcfg;
    // quasi-static: a change mid-frame may tear for one frame
    assign cfg_w = '{pol: cfg0_q[`TDMR_POL_B],
                     edge_fall: cfg1_q[`TDMR_EDGE_B],
                     justify_right: cfg1_q[`TDMR_JUST_B],
                     offset: cfg1_q[`TDMR_OFS_F],
                     chsel: tdmr_pkg::tdmr_chsel_t'(cfg2_q[`TDMR_CHSEL_F]),
                     wlen: cfg2_q[`TDMR_WLEN_F],
                     slen: cfg2_q[`TDMR_SLEN_F],
                     slot_l: cfg3_q[`TDMR_SLOTL_F],
                     slot_r: cfg3_q[`TDMR_SLOTR_F],
                     slot_dev: dev_q[`TDMR_DEV_F]};
    always_ff @(posedge serial_bit_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            lcfg_s1_q <= '0;
            lcfg <= '0;
        end
        else
        begin
            lcfg_s1_q <= cfg_w;
            lcfg <= lcfg_s1_q;
        end
    end

    // ============================================================
    // link capture
    logic pos_fs_q, pos_sd_q, neg_fs_q, neg_sd_q, fs_prev_q;
    always_ff @(posedge serial_bit_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            // sync flops reset high: a low value would fake a frame edge
            // on the first look at an idle-high sync
            pos_fs_q <= 1'b1;
            pos_sd_q <= 1'b0;
        end
        else
        begin
            pos_fs_q <= frame_sync;
            pos_sd_q <= serial_data;
        end
    end
    always_ff @(negedge serial_bit_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            neg_fs_q <= 1'b1;
            neg_sd_q <= 1'b0;
        end
        else
        begin
            neg_fs_q <= frame_sync;
            neg_sd_q <= serial_data;
        end
    end
    wire fs_w = lcfg.edge_fall ? neg_fs_q : pos_fs_q;
    wire sd_w = lcfg.edge_fall ? neg_sd_q : pos_sd_q;
    wire fstart_w = lcfg.pol ? (fs_prev_q & ~fs_w) : (~fs_prev_q & fs_w);

    // ============================================================
    // frame and slot sequencing
    tdmr_pkg::tdmr_state_t st_q, st_d, st_w;
    logic [4:0] lead_q, lead_d, bit_q, bit_d;
    logic [3:0] slot_q, slot_d;
    logic [31:0] shift_q, left_q, right_q, mono_q;
    wire [4:0] cur_lead = fstart_w ? lcfg.offset : lead_q;
    wire [4:0] cur_bit = fstart_w ? '0 : bit_q;
    wire [3:0] cur_slot = fstart_w ? '0 : slot_q;
    assign st_w = !fstart_w ? st_q :
        (lcfg.offset == '0) ? tdmr_pkg::TDMR_ST_DATA : tdmr_pkg::TDMR_ST_LEAD;
    wire [5:0] slen_n = tdmr_pkg::tdmr_slen_bits(lcfg.slen);
    wire [5:0] wlen_n = tdmr_pkg::tdmr_wlen_bits(lcfg.wlen);
    wire take_w = st_w == tdmr_pkg::TDMR_ST_DATA;
    wire slot_end_w = take_w & ({1'b0, cur_bit} == slen_n - 6'd1);

    always_comb
    begin
        st_d = st_w;
        lead_d = cur_lead;
        bit_d = cur_bit;
        slot_d = cur_slot;
        unique case (st_w)
            tdmr_pkg::TDMR_ST_IDLE: st_d = tdmr_pkg::TDMR_ST_IDLE;
            tdmr_pkg::TDMR_ST_LEAD:
            begin
                lead_d = cur_lead - 5'd1;
                if (cur_lead == 5'd1)
                    st_d = tdmr_pkg::TDMR_ST_DATA;
            end
            tdmr_pkg::TDMR_ST_DATA:
            begin
                bit_d = slot_end_w ? '0 : cur_bit + 5'd1;
                if (slot_end_w)
                begin
                    slot_d = cur_slot + 4'd1;
                    // past the last numbered slot nothing more is taken
                    if (cur_slot == '1)
                        st_d = tdmr_pkg::TDMR_ST_IDLE;
                end
            end
        endcase
    end

    // a word longer than its slot just fills the whole slot
    wire [5:0] rstart = (wlen_n > slen_n) ? '0 : slen_n - wlen_n;
    wire in_win = lcfg.justify_right ? ({1'b0, cur_bit} >= rstart)
                                     : ({1'b0, cur_bit} < wlen_n);
    wire [31:0] shift_base = (cur_bit == '0) ? '0 : shift_q;
    wire [31:0] shift_w = in_win ? {shift_base[30:0], sd_w} : shift_base;
    wire [31:0] word_w = 32'(shift_w << (`TDMR_LEN32 - wlen_n));
    wire signed [32:0] sum_w = $signed({left_q[31], left_q})
                             + $signed({right_q[31], right_q});
    wire [31:0] mix_w = sum_w[32:1];
    wire [31:0] sel_w =
        (lcfg.chsel == tdmr_pkg::TDMR_CH_ADDR) ? mono_q :
        (lcfg.chsel == tdmr_pkg::TDMR_CH_LEFT) ? left_q :
        (lcfg.chsel == tdmr_pkg::TDMR_CH_RIGHT) ? right_q : mix_w;
    wire hit_l = slot_end_w & (cur_slot == lcfg.slot_l);
    wire hit_r = slot_end_w & (cur_slot == lcfg.slot_r);
    wire hit_m = slot_end_w & (cur_slot == lcfg.slot_dev);

    always_ff @(posedge serial_bit_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            fs_prev_q <= 1'b1;
            st_q <= tdmr_pkg::TDMR_ST_IDLE;
            lead_q <= '0;
            bit_q <= '0;
            slot_q <= '0;
            shift_q <= '0;
            left_q <= '0;
            right_q <= '0;
            mono_q <= '0;
            link_out_q <= '0;
            tgl_q <= 1'b0;
        end
        else
        begin
            fs_prev_q <= fs_w;
            st_q <= st_d;
            lead_q <= lead_d;
            bit_q <= bit_d;
            slot_q <= slot_d;
            shift_q <= take_w ? shift_w : shift_q;
            left_q <= hit_l ? word_w : left_q;
            right_q <= hit_r ? word_w : right_q;
            mono_q <= hit_m ? word_w : mono_q;
            // previous frame's result goes out as the next frame opens
            link_out_q <= fstart_w ? sel_w : link_out_q;
            tgl_q <= tgl_q ^ fstart_w;
        end
    end

    // ============================================================
    // assertions
    property p_rsvd_zero;
        @(posedge clk) disable iff (!resetn)
        !cfg0_q[`TDMR_RSV_B] && !cfg1_q[`TDMR_RSV_B];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bit holds a one");
    property p_rate_manual;
        @(posedge clk) disable iff (!resetn)
        cfg0_q[`TDMR_AUTO_B] |=> rate_q == $past(cfg0_q[`TDMR_RATE_F]);
    endproperty
    a_rate_manual: assert property (p_rate_manual)
        else $error("rate does not follow programmed code");
    property p_rate_auto;
        @(posedge clk) disable iff (!resetn)
        (ev_w && !cfg0_q[`TDMR_AUTO_B]) ##1 !cfg0_q[`TDMR_AUTO_B]
            |=> rate_q == $past(det_q);
    endproperty
    a_rate_auto: assert property (p_rate_auto)
        else $error("rate does not follow detection");
    property p_lock;
        @(posedge clk) disable iff (!resetn)
        wr_rate |=> ##1 amp_clock_lock == $past(hwdata[`TDMR_LOCK_B], 2);
    endproperty
    a_lock: assert property (p_lock)
        else $error("amp lock does not follow write");
    property p_family;
        @(posedge clk) disable iff (!resetn)
        amp_base_441 |-> $past(cfg0_q[`TDMR_LOCK_B] && cfg0_q[`TDMR_FAM_B]);
    endproperty
    a_family: assert property (p_family)
        else $error("44.1 base without lock and family bit");
    property p_sense;
        @(posedge clk) disable iff (!resetn)
        $past(cfg2_q[`TDMR_SENSE_F]) == 2'b00 |-> sense_word_bits == 6'd8;
    endproperty
    a_sense: assert property (p_sense)
        else $error("sense length not 8 for code 00");
    property p_bus;
        @(posedge clk) disable iff (!resetn)
        hreadyout && !hresp;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus slave stalled or erred");
    property p_offset;
        @(posedge serial_bit_clock) disable iff (!resetn)
        fstart_w && lcfg.offset != '0
            |=> lead_q == $past(lcfg.offset) - 5'd1
            && st_q == (lead_q == '0 ? tdmr_pkg::TDMR_ST_DATA
                                     : tdmr_pkg::TDMR_ST_LEAD);
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset countdown wrong after frame start");
    property p_slot_wrap;
        @(posedge serial_bit_clock) disable iff (!resetn)
        slot_end_w && cur_slot != '1 ##1 !fstart_w
            |-> bit_q == '0 && slot_q == $past(cur_slot) + 4'd1;
    endproperty
    a_slot_wrap: assert property (p_slot_wrap)
        else $error("slot did not advance at slot end");
    property p_pol;
        @(posedge serial_bit_clock) disable iff (!resetn)
        fstart_w |-> fs_prev_q == lcfg.pol && fs_w == !lcfg.pol;
    endproperty
    a_pol: assert property (p_pol)
        else $error("frame start on wrong sync transition");
    property p_mix;
        @(posedge serial_bit_clock) disable iff (!resetn)
        fstart_w && lcfg.chsel == tdmr_pkg::TDMR_CH_MIX
            |=> link_out_q == $past(mix_w);
    endproperty
    a_mix: assert property (p_mix)
        else $error("downmix output wrong");
    property p_left;
        @(posedge serial_bit_clock) disable iff (!resetn)
        fstart_w && lcfg.chsel == tdmr_pkg::TDMR_CH_LEFT
            |=> link_out_q == $past(left_q);
    endproperty
    a_left: assert property (p_left)
        else $error("mono left output wrong");
    property p_dev;
        @(posedge serial_bit_clock) disable iff (!resetn)
        fstart_w && lcfg.chsel == tdmr_pkg::TDMR_CH_ADDR
            |=> link_out_q == $past(mono_q);
    endproperty
    a_dev: assert property (p_dev)
        else $error("address slot output wrong");
    c_sample: cover property (@(posedge clk) disable iff (!resetn)
        sample_valid);
    c_auto: cover property (@(posedge clk) disable iff (!resetn)
        ev_w && det_d != det_q);
    c_mix: cover property (@(posedge serial_bit_clock) disable iff (!resetn)
        fstart_w && lcfg.chsel == tdmr_pkg::TDMR_CH_MIX);
    c_right: cover property (@(posedge serial_bit_clock)
        disable iff (!resetn) slot_end_w && lcfg.justify_right);
endmodule // tdmr_port
`default_nettype wire

// ==== dv/tdmr_host.sv ====
/* host model: sends tdm frames of two 32-bit slots.
   assumes the port captures on either edge: data change midway
   between the edges of a bit clock that stands still between frames. */
`timescale 1ns/10ps
`default_nettype none
module tdmr_host (
    output logic bit_clk,
    output logic fs,
    output logic sd
);
    // ============================================
    // frames
    initial
    begin
        bit_clk = 1'b1;
        fs = 1'b1;
        sd = 1'b0;
    end
    // spare bits toggle, never stale; p set gives a high sync pulse
    task automatic frame(input logic [31:0] a, b, input logic p);
        for (int i = -4; i < 524; i++)
        begin
            bit_clk = 1'b0;
            #1.5;
            fs = (i != 0) ^ p;
            sd = (i > 0 && i < 33) ? a[32-i] :
                (i > 32 && i < 65) ? b[64-i] : i[0];
            #1.5 bit_clk = 1'b1;
            #3;
        end
    endtask
endmodule // tdmr_host
`default_nettype wire

// ==== dv/tdmr_port_test.sv ====
/* bench of the tdm receive port: ahb tasks and host frames.
   assumes a zero-wait slave and the host model. */
`timescale 1ns/10ps
`default_nettype none
module tdmr_port_test;
    logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic hrdy, hresp, bit_clk, fs, sd, sv, lk, b4;
    logic [31:0] hrdata, sdat, q;
    logic [5:0] sw;
    logic [2:0] ar;
    int mismatches = 0, checked = 0;
    tdmr_host i_host (.bit_clk(bit_clk), .fs(fs), .sd(sd));
    tdmr_port i_dut (.clk(clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
        .hrdata(hrdata), .hresp(hresp), .serial_bit_clock(bit_clk),
        .frame_sync(fs), .serial_data(sd), .sample_data(sdat),
        .sample_valid(sv), .amp_clock_lock(lk), .amp_base_441(b4),
        .sense_word_bits(sw), .active_rate(ar));
    // ============================================
    // tasks
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk("register", q, e);
    endtask
    // result of a frame shows only once the next frame starts
    task automatic run(input logic [31:0] l, r, e, input logic p);
        i_host.frame(l, r, p);
        fork
            i_host.frame(32'h0000_0000, 32'h0000_0000, p);
            @(posedge sv) @(negedge clk) chk("sample", sdat, e);
        join
        // back in step with clk before the next bus access
        @(posedge clk);
    endtask
    task automatic summarize;
        if (mismatches == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ============================================
    // tests
    initial
        forever #5 clk = ~clk;
    initial
    begin
        #100000;
        mismatches++;
        summarize;
    end
    initial
    begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("sense", 32'(sw), 32'h0000_0010);
        rd(8'h18, 32'h0000_0009);
        rd(8'h1c, 32'h0000_0002);
        rd(8'h20, 32'h0000_004a);
        rd(8'h3c, 32'h0000_0000);
        bus(1'b1, 8'h18, 32'hffff_fff9);
        rd(8'h18, 32'h0000_0079);
        chk("lock", 32'(lk), 32'h0000_0001);
        chk("base", 32'(b4), 32'h0000_0001);
        chk("rate", 32'(ar), 32'h0000_0004);
        bus(1'b1, 8'h18, 32'h0000_0029);
        rd(8'h18, 32'h0000_0029);
        chk("base", 32'(b4), 32'h0000_0000);
        run(32'ha5c3_9601, 32'h1234_5678, 32'ha5c3_9600, 1'b0);
        bus(1'b1, 8'h1c, 32'h0000_0042);
        run(32'ha5c3_9601, 32'h1234_5678, 32'hc396_0100, 1'b0);
        bus(1'b1, 8'h1c, 32'h0000_0002);
        bus(1'b1, 8'h20, 32'h0000_00fa);
        repeat (2) @(posedge clk);
        chk("sense", 32'(sw), 32'h0000_0020);
        run(32'h8000_0000, 32'h4000_0000, 32'he000_0000, 1'b0);
        bus(1'b1, 8'h20, 32'h0000_00e2);
        run(32'h1111_1111, 32'h2222_2222, 32'h2222_0000, 1'b0);
        bus(1'b1, 8'h18, 32'h0000_0028);
        bus(1'b1, 8'h1c, 32'h0000_0003);
        bus(1'b1, 8'h20, 32'h0000_0022);
        repeat (2) @(posedge clk);
        chk("sense", 32'(sw), 32'h0000_0008);
        run(32'h1111_1111, 32'hc0de_5a5a, 32'hc0de_0000, 1'b1);
        rd(8'h30, 32'hc0de_0000);
        rd(8'h2c, 32'h0000_0006);
        summarize;
    end
endmodule // tdmr_port_test
`default_nettype wire
